// ### rtl/srt_pkg.sv
// package of the synthesizer ratio and frequency trim register block
// assumes byte-wide register access from a serial configuration port decoder
package srt_pkg;

	// ==========================================================
	// register byte addresses (first byte holds the top byte)
	localparam logic [7:0]  SRT_OFS_RATIO    = 8'h5c;
	localparam logic [7:0]  SRT_OFS_GATES    = 8'h71;
	localparam logic [7:0]  SRT_OFS_TRIM     = 8'h73;

	// ==========================================================
	// field positions
	localparam int          SRT_DEN_LSB      = 0;
	localparam int          SRT_NUM_LSB      = 16;
	localparam int          SRT_HALF_W       = 16;
	localparam int          SRT_GATE_W       = 2;

	// ==========================================================
	// values after reset
	localparam logic [31:0] SRT_RST_RATIO    = 32'h0001_0001;
	localparam logic [7:0]  SRT_RST_GATES    = 8'h03;
	localparam logic [31:0] SRT_RST_TRIM     = 32'h046a_aaab;

	// ==========================================================
	// byte counts and lane of the byte that commits a wide value
	localparam int          SRT_WIDE_BYTES   = 4;
	localparam logic [1:0]  SRT_LAST_LANE    = 2'h3;

endpackage : srt_pkg

// ### rtl/srt_wide_reg.sv
// 32-bit register written one byte at a time through a staging copy
// assumes the caller decodes the byte lane; lane 0 is the top byte
`timescale 1ns/1ps

module srt_wide_reg #(
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_wr_en,
	input  wire logic [1:0]  i_lane,
	input  wire logic [7:0]  i_wr_data,
	output logic      [31:0] o_staged,
	output logic      [31:0] o_active,
	output logic             o_commit
);

	typedef struct packed {
		logic [31:0] staged;
		logic [31:0] active;
		logic        commit;
	} srt_wide_s;

	srt_wide_s st_r;
	srt_wide_s st_nxt;

	// ==========================================================
	// staging and commit
	// bytes land in the staging copy; the last lane moves it to the live copy
	always_comb begin
		st_nxt        = st_r;
		st_nxt.commit = 1'b0;
		if (i_wr_en) begin
			st_nxt.staged[8*(3-i_lane) +: 8] = i_wr_data;
			if (i_lane == srt_pkg::SRT_LAST_LANE) begin
				st_nxt.active = st_nxt.staged;
				st_nxt.commit = 1'b1;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '{staged: RST_VAL, active: RST_VAL, commit: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_staged = st_r.staged;
	assign o_active = st_r.active;
	assign o_commit = st_r.commit;

endmodule : srt_wide_reg

// ### rtl/srt_regs.sv
// synthesizer ratio, output gate and central frequency trim registers
// assumes a serial port decoder gives one byte write or read per strobe
// and that the synthesizers use the live values driven out here
`timescale 1ns/1ps

module srt_regs (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wr_data,
	output logic      [7:0]  o_rd_data,
	output logic      [15:0] o_second_synth_numerator,
	output logic      [15:0] o_second_synth_denominator,
	output logic      [1:0]  o_synth_out_en,
	output logic      [31:0] o_freq_trim,
	output logic             o_ratio_applied,
	output logic             o_trim_applied
);

	// ==========================================================
	// address decode
	// returns {hit, lane} for a four-byte register at base
	function automatic logic [2:0] srt_slot(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] diff;
		diff     = addr - base;
		srt_slot = {(addr >= base) && (diff < 8'h04), diff[1:0]};
	endfunction : srt_slot

	logic [2:0]  ratio_slot;
	logic [2:0]  trim_slot;
	logic        gates_hit;
	logic [31:0] ratio_staged;
	logic [31:0] ratio_active;
	logic [31:0] trim_staged;

	// byte slots of the two wide registers and the gate register hit
	assign ratio_slot = srt_slot(i_addr, srt_pkg::SRT_OFS_RATIO);
	assign trim_slot  = srt_slot(i_addr, srt_pkg::SRT_OFS_TRIM);
	assign gates_hit  = (i_addr == srt_pkg::SRT_OFS_GATES);

	// ==========================================================
	// wide registers
	// ratio for the second synthesizer, applied as a whole word
	srt_wide_reg #(
		.RST_VAL (srt_pkg::SRT_RST_RATIO)
	) u_ratio (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_wr_en   (i_wr_en && ratio_slot[2]),
		.i_lane    (ratio_slot[1:0]),
		.i_wr_data (i_wr_data),
		.o_staged  (ratio_staged),
		.o_active  (ratio_active),
		.o_commit  (o_ratio_applied)
	);

	// one trim word shared by all synthesizers
	srt_wide_reg #(
		.RST_VAL (srt_pkg::SRT_RST_TRIM)
	) u_trim (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_wr_en   (i_wr_en && trim_slot[2]),
		.i_lane    (trim_slot[1:0]),
		.i_wr_data (i_wr_data),
		.o_staged  (trim_staged),
		.o_active  (o_freq_trim),
		.o_commit  (o_trim_applied)
	);

	// ratio halves feed the synthesizer multiply (den in low half)
	assign o_second_synth_denominator = ratio_active[srt_pkg::SRT_DEN_LSB +: srt_pkg::SRT_HALF_W];
	assign o_second_synth_numerator   = ratio_active[srt_pkg::SRT_NUM_LSB +: srt_pkg::SRT_HALF_W];

	// ==========================================================
	// gate register and read data
	typedef struct packed {
		logic [1:0] gates;
		logic [7:0] rd_data;
	} srt_regs_s;

	srt_regs_s st_r;
	srt_regs_s st_nxt;

	// byte writes to the gate register, reads return the staged bytes of the wide registers or the live gates
	always_comb begin
		st_nxt = st_r;
		if (i_wr_en && gates_hit) begin
			st_nxt.gates = i_wr_data[srt_pkg::SRT_GATE_W-1:0];
		end
		if (i_rd_en) begin
			if (ratio_slot[2]) begin
				st_nxt.rd_data = ratio_staged[8*(3-ratio_slot[1:0]) +: 8];
			end else if (trim_slot[2]) begin
				st_nxt.rd_data = trim_staged[8*(3-trim_slot[1:0]) +: 8];
			end else if (gates_hit) begin
				st_nxt.rd_data = {6'h00, st_r.gates}; // reserved bits read zero
			end else begin
				st_nxt.rd_data = 8'h00;
			end
		end
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '{gates: srt_pkg::SRT_RST_GATES[1:0], rd_data: 8'h00};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_synth_out_en = st_r.gates;
	assign o_rd_data      = st_r.rd_data;

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// write of the lowest ratio byte lands in the denominator next cycle
	ratio_den_low_a : assert property (
		(i_wr_en && i_addr == 8'h5f) |=> o_second_synth_denominator[7:0] == $past(i_wr_data))
		else $error("ratio low byte did not reach the denominator");

	// a top byte then the last byte puts the first into the numerator
	sequence s_ratio_top;
		i_wr_en && i_addr == 8'h5c;
	endsequence
	sequence s_ratio_last;
		i_wr_en && i_addr == 8'h5f;
	endsequence
	ratio_num_top_a : assert property (
		s_ratio_top ##1 s_ratio_last |=> o_second_synth_numerator[15:8] == $past(i_wr_data, 2))
		else $error("ratio top byte did not reach the numerator");

	// gate register follows the two low written bits
	gate_bits_a : assert property (
		(i_wr_en && gates_hit) |=> o_synth_out_en == $past(i_wr_data[1:0]))
		else $error("output gates did not take the written bits");

	// reserved gate bits read back as zero beside the live gates
	gate_readback_a : assert property (
		(i_rd_en && gates_hit && !i_wr_en) |=> o_rd_data == {6'h00, o_synth_out_en})
		else $error("gate register read back wrong");

	// trim holds its reset value while reset is applied
	trim_reset_a : assert property (@(posedge i_clk_sys) disable iff (1'b0)
		!i_rst_n |-> o_freq_trim == 32'h046a_aaab && o_synth_out_en == 2'h3)
		else $error("trim or gates not at reset value");

	// trim second byte then last byte reaches bits 23:16
	sequence s_trim_mid;
		i_wr_en && i_addr == 8'h74;
	endsequence
	sequence s_trim_last;
		i_wr_en && i_addr == 8'h76;
	endsequence
	trim_byte_a : assert property (
		s_trim_mid ##1 s_trim_last |=> o_freq_trim[23:16] == $past(i_wr_data, 2)
			&& o_freq_trim[7:0] == $past(i_wr_data))
		else $error("trim bytes not placed in order");

	// the shared trim changes only on a commit
	trim_hold_a : assert property (
		!o_trim_applied |-> $stable(o_freq_trim))
		else $error("trim changed without its last byte");

	// the ratio seen by the synthesizer changes only on a commit
	ratio_hold_a : assert property (
		!o_ratio_applied |-> $stable(o_second_synth_numerator) && $stable(o_second_synth_denominator))
		else $error("ratio changed without its last byte");

	// the last ratio byte always raises the ratio pulse next cycle
	ratio_commit_a : assert property (
		s_ratio_last |=> o_ratio_applied)
		else $error("ratio last byte did not commit");

	// the last trim byte always raises the trim pulse next cycle
	trim_commit_a : assert property (
		s_trim_last |=> o_trim_applied)
		else $error("trim last byte did not commit");

	// a ratio pulse only follows a write of the last ratio byte
	ratio_pulse_a : assert property (
		o_ratio_applied |-> $past(i_wr_en) && $past(i_addr) == 8'h5f)
		else $error("ratio pulse without its last byte");

	// a trim pulse only follows a write of the last trim byte
	trim_pulse_a : assert property (
		o_trim_applied |-> $past(i_wr_en) && $past(i_addr) == 8'h76)
		else $error("trim pulse without its last byte");

	// gates keep their value unless the gate register is written
	gate_hold_a : assert property (
		!(i_wr_en && gates_hit) |=> $stable(o_synth_out_en))
		else $error("output gates changed without a write");

	// lane 2 then the last lane fills the denominator high byte
	sequence s_ratio_lane2;
		i_wr_en && i_addr == 8'h5e;
	endsequence
	ratio_den_high_a : assert property (
		s_ratio_lane2 ##1 s_ratio_last |=> o_second_synth_denominator[15:8] == $past(i_wr_data, 2))
		else $error("ratio denominator high byte misplaced");

	// lane 2 then the last lane fills trim bits 15:8
	sequence s_trim_lane2;
		i_wr_en && i_addr == 8'h75;
	endsequence
	trim_lane2_a : assert property (
		s_trim_lane2 ##1 s_trim_last |=> o_freq_trim[15:8] == $past(i_wr_data, 2))
		else $error("trim bits 15:8 misplaced");

	// the last trim byte lands in the lowest trim bits
	trim_low_byte_a : assert property (
		s_trim_last |=> o_freq_trim[7:0] == $past(i_wr_data))
		else $error("trim low byte misplaced");

endmodule : srt_regs

// ### test/srt_host_model.sv
// host model of the serial port decoder: one byte write or read per call
// assumes the bench supplies the clock and calls the tasks in order
`timescale 1ns/1ps

module srt_host_model (
	input  wire logic       i_clk_sys,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wr_data
);
	// ==========================================================
	// port quiet at time zero
	initial begin
		o_wr_en   = 1'b0;
		o_rd_en   = 1'b0;
		o_addr    = 8'h00;
		o_wr_data = 8'h00;
	end

	// one strobe launched just after a rising edge, taken at the next
	task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		o_wr_en   <= w;
		o_rd_en   <= ~w;
		o_addr    <= a;
		o_wr_data <= d;
	endtask : put

	// strobes drop; address and data lines show the inverse of their last value
	task automatic idle();
		@(posedge i_clk_sys);
		o_wr_en   <= 1'b0;
		o_rd_en   <= 1'b0;
		o_addr    <= ~o_addr;
		o_wr_data <= ~o_wr_data;
	endtask : idle
endmodule : srt_host_model

// ### test/synth_ratio_trim_regs_tb_top.sv
// self-checking bench of the ratio, gate and trim registers
// assumes the host model drives the byte port of the design
`timescale 1ns/1ps

module synth_ratio_trim_regs_tb_top;
	logic        i_clk_sys;
	logic        i_rst_n;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rd_data;
	logic [15:0] num;
	logic [15:0] den;
	logic [1:0]  out_en;
	logic [31:0] trim;
	logic        ratio_ap;
	logic        trim_ap;
	logic [31:0] st_r, st_t, ex_r, ex_t, rnd;
	logic [7:0]  ex_g;
	int          err_count = 0;
	int          n_tests = 0;

	// ==========================================================
	// clock and instances
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	srt_host_model srt_host_model_inst (.i_clk_sys(i_clk_sys), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdata));
	srt_regs srt_regs_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wdata), .o_rd_data(rd_data),
		.o_second_synth_numerator(num), .o_second_synth_denominator(den),
		.o_synth_out_en(out_en), .o_freq_trim(trim), .o_ratio_applied(ratio_ap),
		.o_trim_applied(trim_ap));

	// ==========================================================
	// expectation helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] lane(input logic [31:0] v, input int i);
		return v[31 - 8 * i -: 8];
	endfunction : lane
	// signed trim kept inside five percent of nominal
	function automatic logic [31:0] bound5(input logic [31:0] s);
		return s[31] ? -(s % 32'h0ccc_cccc) : s % 32'h0ccc_cccc;
	endfunction : bound5

	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		srt_host_model_inst.put(1'b0, a, 8'h00);
		srt_host_model_inst.idle();
		@(negedge i_clk_sys);
		chk("rd_data", 32'(e), 32'(rd_data));
	endtask : rdc
	task automatic live();
		chk("numerator", 32'(ex_r[31:16]), 32'(num));
		chk("denominator", 32'(ex_r[15:0]), 32'(den));
		chk("out_en", 32'(ex_g[1:0]), 32'(out_en));
		chk("trim", ex_t, trim);
	endtask : live
	// byte lanes lo..hi of a wide value, then check pulse and live value
	task automatic ww(input logic [7:0] b, input logic [31:0] v, input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			srt_host_model_inst.put(1'b1, b + 8'(i), lane(v, i));
			if (b == 8'h73) st_t[31 - 8 * i -: 8] = lane(v, i);
			else st_r[31 - 8 * i -: 8] = lane(v, i);
		end
		srt_host_model_inst.idle();
		@(negedge i_clk_sys);
		if (hi == 3 && b == 8'h73) ex_t = st_t;
		if (hi == 3 && b == 8'h5c) ex_r = st_r;
		chk("trim_applied", 32'(hi == 3 && b == 8'h73), 32'(trim_ap));
		chk("ratio_applied", 32'(hi == 3 && b == 8'h5c), 32'(ratio_ap));
		live();
		@(negedge i_clk_sys);
		chk("pulse_len", 32'h0, 32'(trim_ap | ratio_ap));
	endtask : ww

	// ==========================================================
	// main sequence
	initial begin
		i_rst_n = 1'b1;
		#1;
		i_rst_n = 1'b0;
		rnd = 32'h5b99;
		ex_r = 32'h0001_0001;
		st_r = ex_r;
		ex_t = 32'h046a_aaab;
		st_t = ex_t;
		ex_g = 8'h03;
		repeat (5) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(negedge i_clk_sys);
		live();
		for (int i = 0; i < 4; i++) begin
			rdc(8'h5c + 8'(i), lane(ex_r, i));
			rdc(8'h73 + 8'(i), lane(ex_t, i));
		end
		// every gate code, junk in the reserved bits
		for (int g = 0; g < 4; g++) begin
			rnd = lfsr(rnd);
			srt_host_model_inst.put(1'b1, 8'h71, {rnd[7:2], 2'(g)});
			srt_host_model_inst.idle();
			ex_g = {6'h00, 2'(g)};
			@(negedge i_clk_sys);
			live();
			rdc(8'h71, ex_g);
		end
		// unmapped places ignore writes and read zero
		srt_host_model_inst.put(1'b1, 8'h72, 8'hff);
		srt_host_model_inst.put(1'b1, 8'h77, 8'hff);
		rdc(8'h72, 8'h00);
		rdc(8'h77, 8'h00);
		rdc(8'h71, ex_g);
		// partial write stays staged until the last lane
		rnd = lfsr(rnd);
		ww(8'h73, rnd, 0, 2);
		for (int i = 0; i < 3; i++) rdc(8'h73 + 8'(i), lane(rnd, i));
		ww(8'h73, rnd, 3, 3);
		ww(8'h73, 32'h0539_782a, 0, 3);
		// lane 1 straight before the last lane, other staged bytes kept
		rnd = lfsr(rnd);
		srt_host_model_inst.put(1'b1, 8'h74, rnd[15:8]);
		srt_host_model_inst.put(1'b1, 8'h76, rnd[7:0]);
		srt_host_model_inst.idle();
		st_t[23:16] = rnd[15:8];
		st_t[7:0] = rnd[7:0];
		ex_t = st_t;
		@(negedge i_clk_sys);
		chk("trim_applied", 32'h1, 32'(trim_ap));
		live();
		ww(8'h5c, 32'hffff_0000, 0, 3);
		repeat (20) begin
			rnd = lfsr(rnd);
			ww(8'h73, bound5(rnd), 0, 3);
			rnd = lfsr(rnd);
			ww(8'h5c, rnd, 0, 3);
		end
		for (int i = 0; i < 4; i++) rdc(8'h5c + 8'(i), lane(ex_r, i));
		ww(8'h5c, 32'h0001_0001, 0, 3);
		// leave ratio and gates off their defaults before the second reset
		ww(8'h5c, 32'h00ff_00ed, 0, 3);
		srt_host_model_inst.put(1'b1, 8'h71, 8'h00);
		srt_host_model_inst.idle();
		// second reset in mid-run restores the defaults
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		@(negedge i_clk_sys);
		ex_r = 32'h0001_0001;
		ex_t = 32'h046a_aaab;
		ex_g = 8'h03;
		live();
		chk("rd_reset", 32'h0, 32'(rd_data));
		chk("pulse_reset", 32'h0, 32'(trim_ap | ratio_ap));
		// release again: staged copies read back their defaults
		@(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rdc(8'h5c + 8'(i), lane(ex_r, i));
			rdc(8'h73 + 8'(i), lane(ex_t, i));
		end
		print_verdict();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		err_count++;
		print_verdict();
	end
endmodule : synth_ratio_trim_regs_tb_top
